// >>> src/mswd_pkg.sv
// Purpose: shared constants for the multimode spi watchdog
// Assumes: 10 MHz core clock, spi frames of 16 bits
// Notes: period table returns zero for reserved codes
package mswd_pkg;
  // register offsets
  localparam logic [6:0] ADDR_METHOD_ACTION = 7'h13;
  localparam logic [6:0] ADDR_PERIOD_COUNT = 7'h14;
  localparam logic [6:0] ADDR_SERVICE_TRIG = 7'h15;
  localparam logic [6:0] ADDR_PULSE_WIDTH = 7'h16;
  localparam logic [6:0] ADDR_CHALLENGE_CFG = 7'h2D;
  localparam logic [6:0] ADDR_CHALLENGE_IN = 7'h2E;
  localparam logic [6:0] ADDR_CHALLENGE_OUT = 7'h2F;
  // field positions
  localparam int METHOD_LSB = 6;
  localparam int PRESCALE_LSB = 4;
  localparam int FAILCNT_LSB = 2;
  localparam int TIMER_LSB = 5;
  localparam int THRESH_LSB = 3;
  localparam int ENABLE_BIT = 0;
  localparam int ANSCNT_LSB = 4;
  localparam int ANSERR_BIT = 6;
  localparam int WRITE_FLAG_BIT = 7;
  // method codes
  localparam logic [1:0] METHOD_AUTONOMOUS = 2'h0;
  localparam logic [1:0] METHOD_TIMEOUT = 2'h1;
  localparam logic [1:0] METHOD_WINDOW = 2'h2;
  localparam logic [1:0] METHOD_CHALLENGE = 2'h3;
  // operating modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SILENT = 2'h1;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] MODE_SLEEP = 2'h3;
  // failure thresholds
  localparam logic [3:0] THRESH_FIRST = 4'h1;
  localparam logic [3:0] THRESH_FIFTH = 4'h5;
  localparam logic [3:0] THRESH_NINTH = 4'h9;
  localparam logic [3:0] FAIL_MAX = 4'hF;
  // reset values and counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] QUESTION_RESET = 4'h0;
  localparam logic [3:0] QUESTION_RESTART = 4'h1;
  localparam logic [2:0] ANSWERS_IN_FIRST = 3'h3;
  localparam logic [4:0] ADDR_BITS_DONE = 5'h08;
  localparam logic [4:0] FRAME_BITS_DONE = 5'h10;
  // timing
  localparam int MS_IN_NS = 1000000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

  typedef logic [15:0] mswd_ms_type;

  // period in ms for timer and prescale codes
  function automatic mswd_ms_type mswd_period_ms(input logic [2:0] tmr, input logic [1:0] pre);
    mswd_ms_type tbl [0:27];
    tbl = '{16'h0004, 16'h0008, 16'h000C, 16'h0010, 16'h0020, 16'h0040, 16'h0060,
            16'h0080, 16'h0080, 16'h0100, 16'h0180, 16'h0200, 16'h0100, 16'h0180,
            16'h0200, 16'h0300, 16'h0200, 16'h0400, 16'h0600, 16'h0800, 16'h0800,
            16'h1000, 16'h1800, 16'h2000, 16'h2800, 16'h4F10, 16'h0000, 16'h0000};
    if (tmr == 3'h7)
      return 16'h0000;
    return tbl[{tmr, pre}];
  endfunction : mswd_period_ms
endpackage : mswd_pkg

// >>> src/mswd_timer.sv
// Purpose: millisecond period timer with half and full marks
// Assumes: period_ms even and nonzero while run is high
// Notes: restart clears the elapsed time to zero
module mswd_timer import mswd_pkg::*;
#(
  parameter int CYC_MS = CYCLES_PER_MS
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  input wire mswd_ms_type period_ms,
  output logic half_reached,
  output logic full_pulse
);
  logic [15:0] cyc;
  logic [15:0] elapsed;
  wire tick = run && (cyc == 16'(CYC_MS - 1));
  wire last_ms = tick && (16'(elapsed + 16'h0001) >= period_ms);

  // cycle prescaler and elapsed milliseconds
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc <= 16'h0000;
      elapsed <= 16'h0000;
      half_reached <= 1'b0;
      full_pulse <= 1'b0;
    end
    else
    begin
      cyc <= (restart || !run || tick) ? 16'h0000 : 16'(cyc + 16'h0001);
      elapsed <= (restart || last_ms) ? 16'h0000 : (tick ? 16'(elapsed + 16'h0001) : elapsed);
      half_reached <= !(restart || last_ms) && ((tick ? 16'(elapsed + 16'h0001) : elapsed) >= (period_ms >> 1));
      full_pulse <= last_ms && !restart;
    end
  end
endmodule : mswd_timer

// >>> src/mswd_core.sv
// Purpose: watchdog with autonomous, time-out, window and challenge modes behind spi
// Assumes: op_mode, mode_change, wake inputs and expected_answer come from core_clk logic
// Notes: spi lines are sampled by core_clk; frame is 16 bits, msb first, write flag first
//
// Overview of operation
// - watchdog off after reset; once enabled a mode transition is the first trigger
// - all variants in normal or silent; standby forces time-out unless autonomous
// - in sleep the watchdog timer stops completely
// - failure counter goes up on misses or bad triggers, down on good, floor zero
// - error event on first failure by default, or on fifth or ninth
// - failure count readable as two bits of the method register
// - method field picks autonomous, time-out, window or challenge operation
// - period in ms comes from prescale and timer fields
// - period table per codes; reserved codes give no period
// - rewriting timing while running halts until the next trigger
// - autonomous: wake in standby triggers; wake in sleep goes standby and triggers
// - autonomous: wake clear in standby disables watchdog and drives receive pin high
// - other variants start only on mode transition; autonomous in normal always runs
// - window: closed half then open half; trigger valid only in open half
// - window: a trigger ends the window and starts a fresh closed one
// - challenge answer is four bytes, each in order and in time
// - challenge cycle is two response windows of half the period each
// - final byte in second window restarts cycle; good sequence makes new question
// - bad answer keeps question and counts failure; threshold fires failure action
// - answers need no question read; other commands may interleave
// - four bit question from a sequence, readable at any time
module mswd_core import mswd_pkg::*;
#(
  parameter int CYC_MS = CYCLES_PER_MS
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic [1:0] op_mode,
  input wire logic mode_change,
  input wire logic wake_event,
  input wire logic wake_clear,
  input wire logic [7:0] expected_answer,
  output logic [1:0] answer_index,
  output logic fail_event,
  output logic rxd_force_high,
  output logic standby_request
);
  // spi line synchronisers
  logic [2:0] sclk_q;
  logic [1:0] cs_q;
  logic [1:0] sdi_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 3'h0;
      cs_q <= 2'h3;
      sdi_q <= 2'h0;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], spi_sclk};
      cs_q <= {cs_q[0], spi_cs_n};
      sdi_q <= {sdi_q[0], spi_sdi};
    end
  end
  wire cs_act = !cs_q[1];
  wire sclk_rise = cs_act && sclk_q[1] && !sclk_q[2];
  wire sclk_fall = cs_act && !sclk_q[1] && sclk_q[2];

  // registers
  logic [1:0] method;
  logic [1:0] prescale;
  logic [1:0] action;
  logic [2:0] period_select_field;
  logic [1:0] failure_threshold_field;
  logic enable;
  logic [7:0] pulse_width;
  logic [7:0] challenge_cfg;
  logic [3:0] fail_cnt;
  logic [3:0] challenge_value;
  logic [2:0] ans_cnt;
  logic ans_err;
  logic seq_err;
  logic running;
  logic halted;

  // spi shifter state
  logic [4:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] frame_addr;
  logic [7:0] sdo_shift;
  logic wr_stb;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  wire [7:0] next_addr = {shift_in[6:0], sdi_q[1]};
  wire [4:0] next_bit_cnt = 5'(bit_cnt + 5'h01);

  // read data for the address just received
  wire [3:0] fail_show = (fail_cnt > 4'h3) ? 4'h3 : fail_cnt;
  wire [7:0] rd_cfg1 = {method, prescale, fail_show[1:0], action};
  wire [7:0] rd_cfg2 = {period_select_field, failure_threshold_field, 2'h0, enable};
  wire [7:0] rd_quest = {1'b0, ans_err, ans_cnt[1:0], challenge_value};
  wire [6:0] ra = next_addr[6:0];
  wire [7:0] rd_data = (ra == ADDR_METHOD_ACTION) ? rd_cfg1 :
                       (ra == ADDR_PERIOD_COUNT) ? rd_cfg2 :
                       (ra == ADDR_PULSE_WIDTH) ? pulse_width :
                       (ra == ADDR_CHALLENGE_CFG) ? challenge_cfg :
                       (ra == ADDR_CHALLENGE_OUT) ? rd_quest : RESET_BYTE;

  // spi frame: address byte then data byte
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt <= 5'h00;
      shift_in <= RESET_BYTE;
      frame_addr <= RESET_BYTE;
      sdo_shift <= RESET_BYTE;
      spi_sdo_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= RESET_BYTE;
    end
    else
    begin
      spi_sdo_oe <= cs_act;
      wr_stb <= sclk_rise && (next_bit_cnt == FRAME_BITS_DONE) && frame_addr[WRITE_FLAG_BIT];
      wr_addr <= frame_addr[6:0];
      wr_data <= next_addr;
      if (!cs_act)
        bit_cnt <= 5'h00;
      else if (sclk_rise)
        bit_cnt <= next_bit_cnt;
      if (sclk_rise)
        shift_in <= next_addr;
      if (sclk_rise && next_bit_cnt == ADDR_BITS_DONE)
        frame_addr <= next_addr;
      if (sclk_rise && next_bit_cnt == ADDR_BITS_DONE)
        sdo_shift <= rd_data;
      else if (sclk_fall && bit_cnt > ADDR_BITS_DONE)
        sdo_shift <= {sdo_shift[6:0], 1'b0};
    end
  end
  assign spi_sdo = sdo_shift[7];

  // decoded writes
  wire wr_cfg1 = wr_stb && wr_addr == ADDR_METHOD_ACTION;
  wire wr_cfg2 = wr_stb && wr_addr == ADDR_PERIOD_COUNT;
  wire trig_wr = wr_stb && wr_addr == ADDR_SERVICE_TRIG;
  wire ans_wr = wr_stb && wr_addr == ADDR_CHALLENGE_IN;
  wire timing_wr = (wr_cfg1 && wr_data[PRESCALE_LSB +: 2] != prescale) ||
                   (wr_cfg2 && wr_data[TIMER_LSB +: 3] != period_select_field);

  // operating context
  wire in_sleep = op_mode == MODE_SLEEP;
  wire in_standby = op_mode == MODE_STANDBY;
  wire auto_sel = method == METHOD_AUTONOMOUS;
  wire [1:0] eff_method = (in_standby && !auto_sel) ? METHOD_TIMEOUT : method;
  wire is_window = eff_method == METHOD_WINDOW;
  wire is_qa = eff_method == METHOD_CHALLENGE;
  wire [15:0] period_ms = mswd_period_ms(period_select_field, prescale);
  wire period_ok = period_ms != 16'h0000;
  wire half_reached;
  wire full_pulse;

  // trigger and start sources
  wire wake_trig = enable && auto_sel && wake_event && (in_standby || in_sleep);
  wire start_evt = enable && !in_sleep && (mode_change ||
                   (auto_sel && op_mode == MODE_NORMAL && !running));
  wire svc_trig = (trig_wr && !is_qa) || wake_trig;
  wire release_halt = running && halted && svc_trig;
  wire live = running && !halted;
  wire judge_trig = live && svc_trig && !in_sleep;
  wire trig_bad = judge_trig && is_window && !half_reached;
  wire ans_live = live && is_qa && ans_wr && !in_sleep;
  wire ans_match = wr_data == expected_answer;
  wire qa_first_over = ans_live && !half_reached && ans_cnt == ANSWERS_IN_FIRST;
  wire qa_final = ans_live && half_reached;
  wire qa_good = qa_final && ans_cnt == ANSWERS_IN_FIRST && !ans_err && !seq_err && ans_match;
  wire qa_end = qa_first_over || (qa_final && (ans_cnt == ANSWERS_IN_FIRST || ans_cnt == 3'h4));
  wire missed = live && full_pulse && !in_sleep;
  wire good = (judge_trig && !trig_bad) || qa_good;
  wire bad = trig_bad || missed || (qa_end && !qa_good);
  wire restart = start_evt || svc_trig || qa_end || missed;
  wire [3:0] thresh = (failure_threshold_field == 2'h1) ? THRESH_FIFTH :
                      (failure_threshold_field == 2'h2) ? THRESH_NINTH : THRESH_FIRST;
  wire [3:0] next_fail = bad ? ((fail_cnt == FAIL_MAX) ? fail_cnt : 4'(fail_cnt + 4'h1)) :
                         good ? ((fail_cnt == 4'h0) ? fail_cnt : 4'(fail_cnt - 4'h1)) : fail_cnt;
  wire [3:0] next_question = (challenge_value == 4'h0) ? QUESTION_RESTART :
                             {challenge_value[2:0], challenge_value[3] ^ challenge_value[2]};

  // period timer, frozen in sleep
  mswd_timer #(.CYC_MS(CYC_MS)) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(live && period_ok && !in_sleep),
    .restart(restart),
    .period_ms(period_ms),
    .half_reached(half_reached),
    .full_pulse(full_pulse)
  );

  // configuration registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      method <= METHOD_AUTONOMOUS;
      prescale <= 2'h0;
      action <= 2'h0;
      period_select_field <= 3'h0;
      failure_threshold_field <= 2'h0;
      enable <= 1'b0;
      pulse_width <= RESET_BYTE;
      challenge_cfg <= RESET_BYTE;
    end
    else
    begin
      if (wr_cfg1)
      begin
        method <= wr_data[METHOD_LSB +: 2];
        prescale <= wr_data[PRESCALE_LSB +: 2];
        action <= wr_data[1:0];
      end
      if (wr_cfg2)
      begin
        period_select_field <= wr_data[TIMER_LSB +: 3];
        failure_threshold_field <= wr_data[THRESH_LSB +: 2];
        enable <= wr_data[ENABLE_BIT];
      end
      if (wr_stb && wr_addr == ADDR_PULSE_WIDTH)
        pulse_width <= wr_data;
      if (wr_stb && wr_addr == ADDR_CHALLENGE_CFG)
        challenge_cfg <= wr_data;
    end
  end

  // run, halt and wake control
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running <= 1'b0;
      halted <= 1'b0;
      rxd_force_high <= 1'b0;
      standby_request <= 1'b0;
    end
    else
    begin
      standby_request <= wake_trig && in_sleep;
      if (!enable || (wake_clear && auto_sel && in_standby))
        running <= 1'b0;
      else if (start_evt || wake_trig)
        running <= 1'b1;
      if (!enable || start_evt || release_halt)
        halted <= 1'b0;
      else if (running && timing_wr)
        halted <= 1'b1;
      if (wake_event)
        rxd_force_high <= 1'b0;
      else if (wake_clear && auto_sel && in_standby && enable)
        rxd_force_high <= 1'b1;
    end
  end

  // failure counter, question and answer tracking
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_cnt <= 4'h0;
      fail_event <= 1'b0;
      challenge_value <= QUESTION_RESET;
      ans_cnt <= 3'h0;
      ans_err <= 1'b0;
      seq_err <= 1'b0;
      answer_index <= 2'h3;
    end
    else
    begin
      fail_cnt <= next_fail;
      fail_event <= bad && next_fail >= thresh;
      answer_index <= ~ans_cnt[1:0];
      if (qa_good)
        challenge_value <= next_question;
      if (restart && !ans_live)
      begin
        ans_cnt <= 3'h0;
        seq_err <= 1'b0;
      end
      else if (qa_end)
      begin
        ans_cnt <= 3'h0;
        ans_err <= !ans_match || ans_err;
        seq_err <= 1'b0;
      end
      else if (ans_live)
      begin
        ans_cnt <= 3'(ans_cnt + 3'h1);
        ans_err <= (ans_cnt == 3'h0 && !half_reached) ? !ans_match : (ans_err || !ans_match);
        seq_err <= seq_err || half_reached;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_bad_at_thresh;
    bad && next_fail >= thresh;
  endsequence
  sequence s_good_answer;
    qa_good ##1 1'b1;
  endsequence

  AST_FAIL_EVENT: assert property (s_bad_at_thresh |=> fail_event) else $error("missed fail event");
  AST_FAIL_CAUSE: assert property (fail_event |-> $past(bad)) else $error("fail event without cause");
  AST_FAIL_FLOOR: assert property (good && fail_cnt == 4'h0 |=> fail_cnt == 4'h0) else $error("counter below zero");
  AST_FAIL_UP: assert property (bad && fail_cnt < FAIL_MAX |=> fail_cnt == $past(fail_cnt) + 4'h1)
    else $error("counter not incremented");
  AST_SLEEP_STOP: assert property (in_sleep && !restart |=> $stable(u_timer.elapsed) && !full_pulse)
    else $error("timer runs in sleep");
  AST_OFF_AT_RESET: assert property (!enable |=> !running) else $error("runs while disabled");
  AST_WINDOW_CLOSED: assert property (judge_trig && is_window && !half_reached |=> fail_cnt != 4'h0)
    else $error("closed window trigger accepted");
  AST_NEW_QUESTION: assert property (s_good_answer |-> challenge_value != $past(challenge_value))
    else $error("question not renewed");
  AST_KEEP_QUESTION: assert property (qa_end && !qa_good |=> $stable(challenge_value))
    else $error("question changed after bad answer");
  AST_HALT: assert property (running && timing_wr && enable && !start_evt
    |=> halted [*2] or (halted ##1 !halted)) else $error("no halt on reprogramming");
  AST_WAKE_CLEAR: assert property (wake_clear && auto_sel && in_standby && enable && !wake_event
    |=> rxd_force_high && !running) else $error("wake clear not handled");
endmodule : mswd_core

// >>> testbench/mswd_host_model.sv
// Purpose: host model that drives spi register frames into the watchdog
// Assumes: spi mode 0, 16-bit frames, link clock of 8 core cycles
// Notes: sclk rests low between frames, sdi flips when deselected
module mswd_host_model
(
  input wire logic core_clk,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 4;

  // idle levels from time zero
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end

  // one frame; data byte bits taken at each rising sclk
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {hdr, wd};
    rd = 8'h00;
    @(posedge core_clk);
    #1 spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_sdi = sh[i];
      repeat (HALF) @(posedge core_clk);
      #1 spi_sclk = 1'b1;
      if (i < 8)
        rd = {rd[6:0], spi_sdo_oe ? spi_sdo : 1'bx};
      repeat (HALF) @(posedge core_clk);
      #1 spi_sclk = 1'b0;
    end
    repeat (HALF) @(posedge core_clk);
    #1 spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    repeat (HALF) @(posedge core_clk);
    #1;
  endtask : xfer
endmodule : mswd_host_model

// >>> testbench/tb_multimode_spi_watchdog.sv
// Purpose: self-checking bench for the multimode spi watchdog
// Assumes: CYC_MS shortened to 20 core cycles per ms
// Notes: answer generator is a fixed byte pattern per index
module tb_multimode_spi_watchdog import mswd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CMS = 20;
  localparam int LIMIT = 90000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] op_mode = MODE_NORMAL;
  logic mode_change = 1'b0;
  logic wake_event = 1'b0;
  logic wake_clear = 1'b0;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic fail_event, rxd_force_high, standby_request;
  logic [1:0] answer_index;
  logic [7:0] expected_answer;
  int bad_count = 0;
  int n_compared = 0;
  int cyc_cnt = 0;
  int fail_seen = 0;
  int sby_seen = 0;
  int t0, n0, d, ms;

  // external answer generator stand-in
  assign expected_answer = {6'h2C, answer_index};

  always #50 core_clk = ~core_clk;

  mswd_core #(.CYC_MS(CMS)) i_mswd_core (
    .core_clk(core_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .op_mode(op_mode),
    .mode_change(mode_change), .wake_event(wake_event), .wake_clear(wake_clear),
    .expected_answer(expected_answer), .answer_index(answer_index), .fail_event(fail_event),
    .rxd_force_high(rxd_force_high), .standby_request(standby_request));

  mswd_host_model i_mswd_host_model (
    .core_clk(core_clk), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));

  // event counters and hang ceiling
  always @(posedge core_clk)
  begin
    cyc_cnt++;
    if (fail_event === 1'b1)
      fail_seen++;
    if (standby_request === 1'b1)
      sby_seen++;
    if (cyc_cnt == LIMIT)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] junk;
    i_mswd_host_model.xfer({1'b1, a}, v, junk);
  endtask : wr

  task automatic rchk(input string what, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_mswd_host_model.xfer({1'b0, a}, 8'h00, v);
    check(what, v, e);
  endtask : rchk

  task automatic mode(input logic [1:0] m);
    op_mode = m;
    mode_change = 1'b1;
    cyc(1);
    mode_change = 1'b0;
  endtask : mode

  task automatic wake();
    wake_event = 1'b1;
    cyc(1);
    wake_event = 1'b0;
  endtask : wake

  task automatic do_reset();
    rst_n = 1'b0;
    op_mode = MODE_NORMAL;
    cyc(8);
    rst_n = 1'b1;
    cyc(4);
    fail_seen = 0;
    sby_seen = 0;
  endtask : do_reset

  // reset, then method/prescale and timer/threshold with enable set
  task automatic setup(input logic [1:0] mt, input logic [1:0] pre, input logic [2:0] tm, input logic [1:0] th);
    do_reset();
    wr(ADDR_METHOD_ACTION, {mt, pre, 4'h0});
    wr(ADDR_PERIOD_COUNT, {tm, th, 3'h1});
  endtask : setup

  task automatic wait_fail(input int lim);
    int base;
    base = fail_seen;
    for (int k = 0; k < lim && fail_seen == base; k++)
      cyc(1);
  endtask : wait_fail

  initial
  begin
    do_reset();
    // reset values and access kinds
    check("answer_index", answer_index, 3);
    check("sdo oe idle", spi_sdo_oe, 0);
    rchk("method reg", ADDR_METHOD_ACTION, RESET_BYTE);
    rchk("period reg", ADDR_PERIOD_COUNT, RESET_BYTE);
    rchk("question", ADDR_CHALLENGE_OUT, {4'h0, QUESTION_RESET});
    rchk("trigger reg", ADDR_SERVICE_TRIG, 8'h00);
    rchk("unmapped", 7'h20, 8'h00);
    wr(ADDR_PULSE_WIDTH, 8'hA5);
    wr(ADDR_CHALLENGE_CFG, 8'h5A);
    wr(ADDR_CHALLENGE_OUT, 8'hFF);
    wr(ADDR_METHOD_ACTION, 8'hF3);
    rchk("pulse reg", ADDR_PULSE_WIDTH, 8'hA5);
    rchk("qa cfg", ADDR_CHALLENGE_CFG, 8'h5A);
    rchk("question ro", ADDR_CHALLENGE_OUT, 8'h00);
    rchk("method rw", ADDR_METHOD_ACTION, 8'hF3);
    mode(MODE_NORMAL);
    cyc(1000);
    check("disabled", fail_seen, 0);
    // period codes timed from transition to first miss
    for (int i = 0; i < 5; i++)
    begin
      ms = (i == 4) ? 32 : 4 * (i + 1);
      setup(METHOD_TIMEOUT, 2'(i % 4), (i == 4) ? 3'h1 : 3'h0, 2'h0);
      mode((i == 3) ? MODE_SILENT : MODE_NORMAL);
      t0 = cyc_cnt;
      wait_fail(1000);
      d = cyc_cnt - t0 - ms * CMS;
      check("period", 32'(d >= -1 && d <= 4), 1);
    end
    setup(METHOD_TIMEOUT, 2'h0, 3'h7, 2'h0);
    mode(MODE_NORMAL);
    cyc(3000);
    check("reserved", fail_seen, 0);
    // thresholds of 1st, 5th and 9th failure
    for (int i = 0; i < 4; i++)
    begin
      ms = (i == 3) ? 0 : 4 * i;
      setup(METHOD_TIMEOUT, 2'h0, 3'h0, 2'(i));
      mode(MODE_NORMAL);
      cyc((ms + 1) * 80 - 40);
      check("before thr", fail_seen, 0);
      cyc(80);
      check("at thr", fail_seen, 1);
    end
    // count up, ignored wake, count down, floor, halt on retiming
    setup(METHOD_TIMEOUT, 2'h3, 3'h1, 2'h0);
    mode(MODE_NORMAL);
    wait_fail(2700);
    rchk("count up", ADDR_METHOD_ACTION, 8'h74);
    wake();
    rchk("wake ignored", ADDR_METHOD_ACTION, 8'h74);
    wr(ADDR_SERVICE_TRIG, 8'h00);
    rchk("count down", ADDR_METHOD_ACTION, 8'h70);
    wr(ADDR_SERVICE_TRIG, 8'h00);
    rchk("count floor", ADDR_METHOD_ACTION, 8'h70);
    wr(ADDR_PERIOD_COUNT, 8'h01);
    n0 = fail_seen;
    cyc(1500);
    check("halted", fail_seen, n0);
    wr(ADDR_SERVICE_TRIG, 8'h00);
    rchk("release", ADDR_METHOD_ACTION, 8'h70);
    cyc(100);
    check("new period run", fail_seen, n0);
    cyc(120);
    check("new period miss", fail_seen, n0 + 1);
    // window of 96 ms, above the short range
    setup(METHOD_WINDOW, 2'h2, 3'h1, 2'h0);
    mode(MODE_NORMAL);
    wr(ADDR_SERVICE_TRIG, 8'h00);
    cyc(700);
    wr(ADDR_SERVICE_TRIG, 8'h00);
    cyc(1100);
    wr(ADDR_SERVICE_TRIG, 8'h00);
    check("window fails", fail_seen, 2);
    rchk("window count", ADDR_METHOD_ACTION, 8'hA4);
    setup(METHOD_WINDOW, 2'h2, 3'h1, 2'h0);
    mode(MODE_STANDBY);
    wr(ADDR_SERVICE_TRIG, 8'h00);
    rchk("standby tmo", ADDR_METHOD_ACTION, 8'hA0);
    setup(METHOD_TIMEOUT, 2'h0, 3'h0, 2'h0);
    mode(MODE_NORMAL);
    cyc(10);
    mode(MODE_SLEEP);
    cyc(1000);
    check("sleep", fail_seen, 0);
    // autonomous runs in normal without a transition
    setup(METHOD_AUTONOMOUS, 2'h3, 3'h1, 2'h0);
    wait_fail(2700);
    check("auto runs", fail_seen, 1);
    mode(MODE_STANDBY);
    wake();
    rchk("auto wake", ADDR_METHOD_ACTION, 8'h30);
    mode(MODE_SLEEP);
    wake();
    cyc(2);
    check("standby req", sby_seen, 1);
    mode(MODE_STANDBY);
    wake_clear = 1'b1;
    cyc(1);
    wake_clear = 1'b0;
    cyc(2);
    check("rxd high", rxd_force_high, 1);
    n0 = fail_seen;
    cyc(3000);
    check("auto off", fail_seen, n0);
    wake();
    cyc(2);
    check("rxd drop", rxd_force_high, 0);
    // challenge cycle of 96 ms, above 64 ms
    setup(METHOD_CHALLENGE, 2'h2, 3'h1, 2'h0);
    mode(MODE_NORMAL);
    for (int k = 3; k > 0; k--)
      wr(ADDR_CHALLENGE_IN, {6'h2C, 2'(k)});
    rchk("three answers", ADDR_CHALLENGE_OUT, 8'h30);
    cyc(500);
    wr(ADDR_CHALLENGE_IN, {6'h2C, 2'h0});
    check("qa good", fail_seen, 0);
    check("qa index", answer_index, 3);
    rchk("new question", ADDR_CHALLENGE_OUT, {4'h0, QUESTION_RESTART});
    for (int k = 3; k >= 0; k--)
      wr(ADDR_CHALLENGE_IN, {6'h2C, 2'(k)});
    cyc(2);
    check("qa early", fail_seen, 1);
    rchk("same question", ADDR_CHALLENGE_OUT, {4'h0, QUESTION_RESTART});
    wr(ADDR_CHALLENGE_IN, 8'h00);
    rchk("wrong value", ADDR_CHALLENGE_OUT, {2'h1, 2'h1, QUESTION_RESTART});
    cyc(1900);
    check("qa missed", fail_seen, 2);
    tally_and_finish();
  end
endmodule : tb_multimode_spi_watchdog
